// ===== aprs_pkg.sv
// Package for the alternate pin route selector: register map, field positions, carriers.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package aprs_pkg;

   // Printed offsets are register indices, so the byte address is four times each
   localparam logic [1:0] APRS_IDX_LOGIC_EVENT = 2'h0;
   localparam logic [1:0] APRS_IDX_SERIAL      = 2'h1;
   localparam logic [1:0] APRS_IDX_WAVEFORM    = 2'h2;
   localparam logic [1:0] APRS_IDX_CAPTURE     = 2'h3;
   localparam int         APRS_NUM_REGS        = 4;

   // Address decode: word index in haddr[3:2], rest must be zero
   localparam int          APRS_ADDR_W        = 32;
   localparam logic [31:0] APRS_ADDR_HI_MASK  = 32'hFFFF_FFF0;

   // Writable bits per register; everything else reads zero
   localparam logic [7:0] APRS_MASK_LOGIC_EVENT = 8'h37;
   localparam logic [7:0] APRS_MASK_SERIAL      = 8'h15;
   localparam logic [7:0] APRS_MASK_WAVEFORM    = 8'h3F;
   localparam logic [7:0] APRS_MASK_CAPTURE     = 8'h01;
   localparam logic [7:0] APRS_REG_RESET        = 8'h00;

   // Field positions
   localparam int APRS_BIT_TABLE_ONE_ALT   = 5;
   localparam int APRS_BIT_TABLE_ZERO_ALT  = 4;
   localparam int APRS_BIT_EVENT_TWO_EN    = 2;
   localparam int APRS_BIT_EVENT_ONE_EN    = 1;
   localparam int APRS_BIT_EVENT_ZERO_EN   = 0;
   localparam int APRS_BIT_TWO_WIRE_ALT    = 4;
   localparam int APRS_BIT_SYNC_SERIAL_ALT = 2;
   localparam int APRS_BIT_ASYNC_SERIAL_ALT= 0;
   localparam int APRS_BIT_CAPTURE_ALT     = 0;
   localparam int APRS_WAVE_SPLIT_LO       = 3;

   // AHB encodings
   localparam logic [1:0] APRS_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] APRS_HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] APRS_HSIZE_WORD    = 3'h2;

   // Pin counts: 3 event pins, 2 logic tables, 6 wave pins; serial groups of 2 to 4 lines
   localparam int APRS_EVT_N   = 3;
   localparam int APRS_LUT_N   = 2;
   localparam int APRS_WAVE_N  = 6;
   localparam int APRS_TWI_N   = 2;
   localparam int APRS_SPI_N   = 4;
   localparam int APRS_UART_N  = 3;

   // Bus data-phase states
   typedef enum logic [1:0]
   {
      APRS_ST_IDLE  = 2'b01,
      APRS_ST_WRITE = 2'b10
   } aprs_state_t;

   // One peripheral output lane: level and output enable
   typedef struct packed
   {
      logic dout;
      logic oe;
   } aprs_lane_t;

   // Pin pair: default and alternative position of one lane
   typedef struct packed
   {
      aprs_lane_t dflt;
      aprs_lane_t alt;
   } aprs_pin_pair_t;

   // Register contents
   typedef struct packed
   {
      logic [7:0] logic_event_route_ctrl;
      logic [7:0] serial_route_ctrl;
      logic [7:0] waveform_route_ctrl;
      logic [7:0] capture_timer_route_ctrl;
   } aprs_regs_t;

   // Whole state of the bus slave
   typedef struct packed
   {
      aprs_state_t state;
      logic [1:0]  wr_idx;
      logic [31:0] hrdata;
      aprs_regs_t  regs;
   } aprs_slave_state_t;

endpackage : aprs_pkg

// ===== aprs_lane_route.sv
// One lane router: steers a peripheral lane onto its default or alternative pin.
// A pin not claimed keeps its general-purpose drive and enable.
`timescale 1ns/100ps
module aprs_lane_route
(
   // Select
   input  wire logic               use_alt,
   // Peripheral lane
   input  wire aprs_pkg::aprs_lane_t periph,
   // General-purpose drive for both pin positions
   input  wire aprs_pkg::aprs_lane_t gpio_dflt,
   input  wire aprs_pkg::aprs_lane_t gpio_alt,
   // Resulting pins
   output aprs_pkg::aprs_pin_pair_t pins
);
   import aprs_pkg::*;

   always_comb
   begin
      // Peripheral claims a pin only while it drives it
      pins.dflt = (!use_alt && periph.oe) ? periph : gpio_dflt;
      pins.alt  = ( use_alt && periph.oe) ? periph : gpio_alt;
   end

endmodule : aprs_lane_route

// ===== aprs_pin_route_selector.sv
// Top of the pin route selector: AHB-Lite register slave and pin steering per lane.
// Assumes peripherals give level and enable per lane and gpio gives both pin positions, or the single pin for event outputs.
//
// Operation
// - Control bit 5 of the first register moves logic table one output to its alternative pin.
// - Control bit 4 of the first register moves logic table zero output to its alternative pin.
// - Bits 2 to 0 of the first register enable event output pins two to zero.
// - Bit 4 of the second register moves the two-wire port lines to the alternative pins.
// - Bit 2 of the second register moves the synchronous serial lines to the alternative pins.
// - Bit 0 of the second register moves the asynchronous serial lines to the alternative pins.
// - Bits 5 to 3 of the third register move wave outputs five to three only in split mode.
// - Bits 2 to 0 of the third register move wave outputs two to zero in either mode.
// - Bit 0 of the fourth register moves the capture timer output to its alternative pin.
// - All four registers reset to zero, so routed lanes start on default pins and event output pins start disabled.
// - Any pin not claimed by a routed peripheral keeps general-purpose behaviour.
`timescale 1ns/100ps
module aprs_pin_route_selector
(
   // Clock and reset
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     clk_en,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic      [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   // Timer mode from the waveform timer
   input  wire logic                     wave_split_mode,
   // Peripheral lanes
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_LUT_N-1:0]  lut_lane,
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_EVT_N-1:0]  evt_lane,
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_TWI_N-1:0]  twi_lane,
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_SPI_N-1:0]  spi_lane,
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_UART_N-1:0] uart_lane,
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_WAVE_N-1:0] wave_lane,
   input  wire aprs_pkg::aprs_lane_t                             cap_lane,
   // General-purpose drive of the pins
   input  wire aprs_pkg::aprs_lane_t [aprs_pkg::APRS_EVT_N-1:0]  gpio_evt,
   input  wire aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_LUT_N-1:0]  gpio_lut,
   input  wire aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_TWI_N-1:0]  gpio_twi,
   input  wire aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_SPI_N-1:0]  gpio_spi,
   input  wire aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_UART_N-1:0] gpio_uart,
   input  wire aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_WAVE_N-1:0] gpio_wave,
   input  wire aprs_pkg::aprs_pin_pair_t                             gpio_cap,
   // Pins
   output aprs_pkg::aprs_lane_t     [aprs_pkg::APRS_EVT_N-1:0]  pin_evt,
   output aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_LUT_N-1:0]  pin_lut,
   output aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_TWI_N-1:0]  pin_twi,
   output aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_SPI_N-1:0]  pin_spi,
   output aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_UART_N-1:0] pin_uart,
   output aprs_pkg::aprs_pin_pair_t [aprs_pkg::APRS_WAVE_N-1:0] pin_wave,
   output aprs_pkg::aprs_pin_pair_t                             pin_cap,
   // Register view
   output aprs_pkg::aprs_regs_t     route_regs
);
   import aprs_pkg::*;

   aprs_slave_state_t st_ff;
   aprs_slave_state_t nxt_st;

   logic       addr_ok;
   logic       take;
   logic [1:0] a_idx;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic [7:0] rd_mask;

   // Legal single word transfer inside the four word window
   assign take    = hsel && hready && (htrans == APRS_HTRANS_NONSEQ || htrans == APRS_HTRANS_SEQ);
   assign addr_ok = ((haddr & APRS_ADDR_HI_MASK) == 32'h0000_0000) && (haddr[1:0] == 2'h0);
   assign a_idx   = haddr[3:2];
   assign wr_byte = hwdata[7:0];

   always_comb
   begin
      case (a_idx)
         APRS_IDX_LOGIC_EVENT: rd_byte = st_ff.regs.logic_event_route_ctrl;
         APRS_IDX_SERIAL:      rd_byte = st_ff.regs.serial_route_ctrl;
         APRS_IDX_WAVEFORM:    rd_byte = st_ff.regs.waveform_route_ctrl;
         APRS_IDX_CAPTURE:     rd_byte = st_ff.regs.capture_timer_route_ctrl;
         default:              rd_byte = 8'h00;
      endcase
      case (a_idx)
         APRS_IDX_LOGIC_EVENT: rd_mask = APRS_MASK_LOGIC_EVENT;
         APRS_IDX_SERIAL:      rd_mask = APRS_MASK_SERIAL;
         APRS_IDX_WAVEFORM:    rd_mask = APRS_MASK_WAVEFORM;
         APRS_IDX_CAPTURE:     rd_mask = APRS_MASK_CAPTURE;
         default:              rd_mask = 8'h00;
      endcase
      // Back to back read of the word being written would otherwise return the stale value
      if (st_ff.state == APRS_ST_WRITE && st_ff.wr_idx == a_idx)
      begin
         rd_byte = wr_byte & rd_mask;
      end
   end

   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff.state)
         APRS_ST_IDLE:
         begin
         end
         APRS_ST_WRITE:
         begin
            // Masked stores drop writes to unused bits
            case (st_ff.wr_idx)
               APRS_IDX_LOGIC_EVENT:
                  nxt_st.regs.logic_event_route_ctrl = wr_byte & APRS_MASK_LOGIC_EVENT;
               APRS_IDX_SERIAL:
                  nxt_st.regs.serial_route_ctrl = wr_byte & APRS_MASK_SERIAL;
               APRS_IDX_WAVEFORM:
                  nxt_st.regs.waveform_route_ctrl = wr_byte & APRS_MASK_WAVEFORM;
               APRS_IDX_CAPTURE:
                  nxt_st.regs.capture_timer_route_ctrl = wr_byte & APRS_MASK_CAPTURE;
               default:
               begin
               end
            endcase
         end
         default:
         begin
         end
      endcase
      nxt_st.state = APRS_ST_IDLE;
      if (take)
      begin
         // Read data is captured in the address phase, so the data phase has no wait
         nxt_st.hrdata = (addr_ok && !hwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
         nxt_st.wr_idx = a_idx;
         if (hwrite && addr_ok && hsize == APRS_HSIZE_WORD)
         begin
            nxt_st.state = APRS_ST_WRITE;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff.state  <= APRS_ST_IDLE;
         st_ff.wr_idx <= 2'h0;
         st_ff.hrdata <= 32'h0000_0000;
         st_ff.regs   <= {APRS_REG_RESET, APRS_REG_RESET, APRS_REG_RESET, APRS_REG_RESET};
      end
      else if (clk_en)
      begin
         st_ff <= nxt_st;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = st_ff.hrdata;
   assign route_regs = st_ff.regs;

   logic ctl_lut_one_alt;
   logic ctl_lut_zero_alt;
   logic ctl_twi_alt;
   logic ctl_spi_alt;
   logic ctl_uart_alt;
   logic ctl_cap_alt;
   logic [APRS_EVT_N-1:0]  ctl_evt_en;
   logic [APRS_WAVE_N-1:0] ctl_wave_alt;

   assign ctl_lut_one_alt  = st_ff.regs.logic_event_route_ctrl[APRS_BIT_TABLE_ONE_ALT];
   assign ctl_lut_zero_alt = st_ff.regs.logic_event_route_ctrl[APRS_BIT_TABLE_ZERO_ALT];
   assign ctl_evt_en  = st_ff.regs.logic_event_route_ctrl[APRS_EVT_N-1:0];
   assign ctl_twi_alt  = st_ff.regs.serial_route_ctrl[APRS_BIT_TWO_WIRE_ALT];
   assign ctl_spi_alt  = st_ff.regs.serial_route_ctrl[APRS_BIT_SYNC_SERIAL_ALT];
   assign ctl_uart_alt = st_ff.regs.serial_route_ctrl[APRS_BIT_ASYNC_SERIAL_ALT];
   assign ctl_cap_alt  = st_ff.regs.capture_timer_route_ctrl[APRS_BIT_CAPTURE_ALT];

   // Upper wave bits only count in split mode; lower ones always
   assign ctl_wave_alt[APRS_WAVE_N-1:APRS_WAVE_SPLIT_LO] =
      st_ff.regs.waveform_route_ctrl[APRS_WAVE_N-1:APRS_WAVE_SPLIT_LO]
      & {3{wave_split_mode}};
   assign ctl_wave_alt[APRS_WAVE_SPLIT_LO-1:0] =
      st_ff.regs.waveform_route_ctrl[APRS_WAVE_SPLIT_LO-1:0];

   // Disabled event pins stay with general-purpose logic
   genvar gi;
   generate
      for (gi = 0; gi < APRS_EVT_N; gi++)
      begin : g_evt
         assign pin_evt[gi] = (ctl_evt_en[gi] && evt_lane[gi].oe) ? evt_lane[gi] : gpio_evt[gi];
      end
      for (gi = 0; gi < APRS_LUT_N; gi++)
      begin : g_lut
         aprs_lane_route u_lut
         (
            .use_alt   ((gi == 1) ? ctl_lut_one_alt : ctl_lut_zero_alt),
            .periph    (lut_lane[gi]),
            .gpio_dflt (gpio_lut[gi].dflt),
            .gpio_alt  (gpio_lut[gi].alt),
            .pins      (pin_lut[gi])
         );
      end
      for (gi = 0; gi < APRS_TWI_N; gi++)
      begin : g_twi
         aprs_lane_route u_twi
         (
            .use_alt   (ctl_twi_alt),
            .periph    (twi_lane[gi]),
            .gpio_dflt (gpio_twi[gi].dflt),
            .gpio_alt  (gpio_twi[gi].alt),
            .pins      (pin_twi[gi])
         );
      end
      for (gi = 0; gi < APRS_SPI_N; gi++)
      begin : g_spi
         aprs_lane_route u_spi
         (
            .use_alt   (ctl_spi_alt),
            .periph    (spi_lane[gi]),
            .gpio_dflt (gpio_spi[gi].dflt),
            .gpio_alt  (gpio_spi[gi].alt),
            .pins      (pin_spi[gi])
         );
      end
      for (gi = 0; gi < APRS_UART_N; gi++)
      begin : g_uart
         aprs_lane_route u_uart
         (
            .use_alt   (ctl_uart_alt),
            .periph    (uart_lane[gi]),
            .gpio_dflt (gpio_uart[gi].dflt),
            .gpio_alt  (gpio_uart[gi].alt),
            .pins      (pin_uart[gi])
         );
      end
      for (gi = 0; gi < APRS_WAVE_N; gi++)
      begin : g_wave
         aprs_lane_route u_wave
         (
            .use_alt   (ctl_wave_alt[gi]),
            .periph    (wave_lane[gi]),
            .gpio_dflt (gpio_wave[gi].dflt),
            .gpio_alt  (gpio_wave[gi].alt),
            .pins      (pin_wave[gi])
         );
      end
   endgenerate

   aprs_lane_route u_cap
   (
      .use_alt   (ctl_cap_alt),
      .periph    (cap_lane),
      .gpio_dflt (gpio_cap.dflt),
      .gpio_alt  (gpio_cap.alt),
      .pins      (pin_cap)
   );

   // Checks
   property p_reg_masked;
      @(posedge hclk) disable iff (!hresetn)
      ((st_ff.regs.logic_event_route_ctrl & ~APRS_MASK_LOGIC_EVENT) == 8'h00)
      && ((st_ff.regs.serial_route_ctrl & ~APRS_MASK_SERIAL) == 8'h00)
      && ((st_ff.regs.capture_timer_route_ctrl & ~APRS_MASK_CAPTURE) == 8'h00);
   endproperty
   a_reg_masked: assert property (p_reg_masked) else $error("unused bit set");

   property p_write_lands;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && take && hwrite && addr_ok && hsize == APRS_HSIZE_WORD
       && a_idx == APRS_IDX_SERIAL) ##1 clk_en |=>
      st_ff.regs.serial_route_ctrl == ($past(hwdata[7:0]) & APRS_MASK_SERIAL);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("serial write lost");

   property p_wave_hi_normal;
      @(posedge hclk) disable iff (!hresetn)
      !wave_split_mode && wave_lane[5].oe |-> pin_wave[5].dflt == wave_lane[5];
   endproperty
   a_wave_hi_normal: assert property (p_wave_hi_normal) else $error("wave5 moved");

   property p_wave_lo_alt;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.regs.waveform_route_ctrl[0] && wave_lane[0].oe |-> pin_wave[0].alt == wave_lane[0];
   endproperty
   a_wave_lo_alt: assert property (p_wave_lo_alt) else $error("wave0 not moved");

   property p_lut_one;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.regs.logic_event_route_ctrl[5] && lut_lane[1].oe |-> pin_lut[1].alt == lut_lane[1];
   endproperty
   a_lut_one: assert property (p_lut_one) else $error("table one not moved");

   property p_lut_zero;
      @(posedge hclk) disable iff (!hresetn)
      !st_ff.regs.logic_event_route_ctrl[4] |-> pin_lut[0].alt == gpio_lut[0].alt;
   endproperty
   a_lut_zero: assert property (p_lut_zero) else $error("table zero claimed alt");

   property p_evt_off;
      @(posedge hclk) disable iff (!hresetn)
      !st_ff.regs.logic_event_route_ctrl[2] |-> pin_evt[2] == gpio_evt[2];
   endproperty
   a_evt_off: assert property (p_evt_off) else $error("event pin two driven");

   property p_cap_alt;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.regs.capture_timer_route_ctrl[0] |-> pin_cap.dflt == gpio_cap.dflt;
   endproperty
   a_cap_alt: assert property (p_cap_alt) else $error("capture default claimed");

   property p_reset_zero;
      @(posedge hclk)
      $rose(hresetn) |-> st_ff.regs == 32'h0000_0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("registers not zero");

   property p_twi_alt;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.regs.serial_route_ctrl[4] && twi_lane[0].oe |-> pin_twi[0].alt == twi_lane[0];
   endproperty
   a_twi_alt: assert property (p_twi_alt) else $error("two-wire not moved");

   property p_spi_dflt;
      @(posedge hclk) disable iff (!hresetn)
      !st_ff.regs.serial_route_ctrl[2] && spi_lane[3].oe |-> pin_spi[3].dflt == spi_lane[3];
   endproperty
   a_spi_dflt: assert property (p_spi_dflt) else $error("sync serial left default");

   property p_uart_alt;
      @(posedge hclk) disable iff (!hresetn)
      st_ff.regs.serial_route_ctrl[0] && uart_lane[2].oe |-> pin_uart[2].alt == uart_lane[2];
   endproperty
   a_uart_alt: assert property (p_uart_alt) else $error("async serial not moved");

   property p_cap_idle;
      @(posedge hclk) disable iff (!hresetn)
      !cap_lane.oe |-> pin_cap == gpio_cap;
   endproperty
   a_cap_idle: assert property (p_cap_idle) else $error("idle capture lane claimed a pin");

endmodule : aprs_pin_route_selector

// ===== aprs_pin_route_selector_tb.sv
// Self-checking bench for the pin route selector: register access over AHB-Lite and pin steering.
// Assumes a single bus master, hready fed back from hreadyout, and all lanes driven from here.
`timescale 1ns/100ps
module aprs_pin_route_selector_tb;
   import aprs_pkg::*;

   // Writable bits per register, index order
   localparam logic [7:0] MASK [4] = '{8'h37, 8'h15, 8'h3F, 8'h01};

   // Clock, reset and bus
   logic                                  hclk;
   logic                                  hresetn;
   logic                                  clk_en;
   logic                                  hsel;
   logic [31:0]                           haddr;
   logic [1:0]                            htrans;
   logic                                  hwrite;
   logic [2:0]                            hsize;
   logic [31:0]                           hwdata;
   logic                                  hready;
   logic [31:0]                           hrdata;
   logic                                  hreadyout;
   logic                                  hresp;
   logic                                  wave_split_mode;
   // Lanes, general-purpose drive and pins
   aprs_lane_t     [APRS_LUT_N-1:0]       lut_lane;
   aprs_lane_t     [APRS_EVT_N-1:0]       evt_lane;
   aprs_lane_t     [APRS_TWI_N-1:0]       twi_lane;
   aprs_lane_t     [APRS_SPI_N-1:0]       spi_lane;
   aprs_lane_t     [APRS_UART_N-1:0]      uart_lane;
   aprs_lane_t     [APRS_WAVE_N-1:0]      wave_lane;
   aprs_lane_t                            cap_lane;
   aprs_lane_t     [APRS_EVT_N-1:0]       gpio_evt;
   aprs_pin_pair_t [APRS_LUT_N-1:0]       gpio_lut;
   aprs_pin_pair_t [APRS_TWI_N-1:0]       gpio_twi;
   aprs_pin_pair_t [APRS_SPI_N-1:0]       gpio_spi;
   aprs_pin_pair_t [APRS_UART_N-1:0]      gpio_uart;
   aprs_pin_pair_t [APRS_WAVE_N-1:0]      gpio_wave;
   aprs_pin_pair_t                        gpio_cap;
   aprs_lane_t     [APRS_EVT_N-1:0]       pin_evt;
   aprs_pin_pair_t [APRS_LUT_N-1:0]       pin_lut;
   aprs_pin_pair_t [APRS_TWI_N-1:0]       pin_twi;
   aprs_pin_pair_t [APRS_SPI_N-1:0]       pin_spi;
   aprs_pin_pair_t [APRS_UART_N-1:0]      pin_uart;
   aprs_pin_pair_t [APRS_WAVE_N-1:0]      pin_wave;
   aprs_pin_pair_t                        pin_cap;
   aprs_regs_t                            route_regs;
   // Bench state
   logic [7:0]                            exp_r [4];
   logic                                  cur_oe;
   logic                                  cur_g;
   int                                    fail_count;
   int                                    checked;
   int                                    cycles;

   assign hready = hreadyout;

   aprs_pin_route_selector u_aprs_pin_route_selector
   (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .wave_split_mode(wave_split_mode), .lut_lane(lut_lane), .evt_lane(evt_lane),
      .twi_lane(twi_lane), .spi_lane(spi_lane), .uart_lane(uart_lane),
      .wave_lane(wave_lane), .cap_lane(cap_lane), .gpio_evt(gpio_evt),
      .gpio_lut(gpio_lut), .gpio_twi(gpio_twi), .gpio_spi(gpio_spi),
      .gpio_uart(gpio_uart), .gpio_wave(gpio_wave), .gpio_cap(gpio_cap),
      .pin_evt(pin_evt), .pin_lut(pin_lut), .pin_twi(pin_twi), .pin_spi(pin_spi),
      .pin_uart(pin_uart), .pin_wave(pin_wave), .pin_cap(pin_cap), .route_regs(route_regs)
   );

   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic end_of_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   // Hang guard: the whole run needs well under two thousand cycles
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         end_of_test;
      end
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Peripheral lane drives 1 with enable oe; gpio default {g,1}, gpio alternative {g,0}
   task automatic set_lanes(input logic oe, input logic g);
      aprs_lane_t p;
      aprs_lane_t d;
      aprs_lane_t a;
      p = {1'b1, oe};
      d = {g, 1'b1};
      a = {g, 1'b0};
      cur_oe = oe;
      cur_g = g;
      lut_lane <= {APRS_LUT_N{p}};
      evt_lane <= {APRS_EVT_N{p}};
      twi_lane <= {APRS_TWI_N{p}};
      spi_lane <= {APRS_SPI_N{p}};
      uart_lane <= {APRS_UART_N{p}};
      wave_lane <= {APRS_WAVE_N{p}};
      cap_lane <= p;
      gpio_evt <= {APRS_EVT_N{d}};
      gpio_lut <= {APRS_LUT_N{d, a}};
      gpio_twi <= {APRS_TWI_N{d, a}};
      gpio_spi <= {APRS_SPI_N{d, a}};
      gpio_uart <= {APRS_UART_N{d, a}};
      gpio_wave <= {APRS_WAVE_N{d, a}};
      gpio_cap <= {d, a};
   endtask : set_lanes

   // A lane without enable claims neither pin, so both stay general-purpose
   function automatic aprs_pin_pair_t exp_pair(input logic sel);
      if (!cur_oe)
         return {cur_g, 1'b1, cur_g, 1'b0};
      else if (sel)
         return {cur_g, 1'b1, 2'b11};
      else
         return {2'b11, cur_g, 1'b0};
   endfunction : exp_pair

   // Master holds each phase until hready is sampled high; read data taken at that edge
   task automatic ahb_xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                           input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      htrans <= APRS_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      check("hresp", 32'h0, 32'(hresp));
   endtask : ahb_xfer

   task automatic wr(input int idx, input logic [7:0] v);
      logic [31:0] r;
      ahb_xfer(1'b1, 32'(idx) << 2, APRS_HSIZE_WORD, {24'hA5A5A5, v}, r);
      if (idx < 4)
         exp_r[idx] = v & MASK[idx];
   endtask : wr

   task automatic rd(input int idx);
      logic [31:0] r;
      ahb_xfer(1'b0, 32'(idx) << 2, APRS_HSIZE_WORD, 32'h0, r);
      check("hrdata", (idx < 4) ? {24'h0, exp_r[idx]} : 32'h0, r);
   endtask : rd

   task automatic check_pins;
      @(posedge hclk);
      #1;
      for (int i = 0; i < APRS_LUT_N; i++)
         check("pin_lut", 32'(exp_pair(exp_r[0][4+i])), 32'(pin_lut[i]));
      for (int i = 0; i < APRS_EVT_N; i++)
         check("pin_evt", (exp_r[0][i] && cur_oe) ? 32'h3 : {30'h0, cur_g, 1'b1},
               32'(pin_evt[i]));
      for (int i = 0; i < APRS_TWI_N; i++)
         check("pin_twi", 32'(exp_pair(exp_r[1][4])), 32'(pin_twi[i]));
      for (int i = 0; i < APRS_SPI_N; i++)
         check("pin_spi", 32'(exp_pair(exp_r[1][2])), 32'(pin_spi[i]));
      for (int i = 0; i < APRS_UART_N; i++)
         check("pin_uart", 32'(exp_pair(exp_r[1][0])), 32'(pin_uart[i]));
      for (int i = 0; i < APRS_WAVE_N; i++)
         check("pin_wave", 32'(exp_pair(exp_r[2][i] && (i < 3 || wave_split_mode))),
               32'(pin_wave[i]));
      check("pin_cap", 32'(exp_pair(exp_r[3][0])), 32'(pin_cap));
      check("route_regs", {exp_r[0], exp_r[1], exp_r[2], exp_r[3]}, route_regs);
   endtask : check_pins

   task automatic test_reset;
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      exp_r = '{default: 8'h00};
      for (int i = 0; i < 4; i++)
         rd(i);
      check_pins;
   endtask : test_reset

   task automatic test_masks;
      logic [31:0] r;
      for (int i = 0; i < 4; i++)
         wr(i, 8'hFF);
      // Byte-sized write is refused; unmapped word neither stores nor reads back
      ahb_xfer(1'b1, 32'h0, 3'h0, 32'h0, r);
      wr(4, 8'hFF);
      rd(4);
      for (int i = 0; i < 4; i++)
         rd(i);
      check_pins;
      wave_split_mode <= 1'b1;
      check_pins;
      wave_split_mode <= 1'b0;
   endtask : test_masks

   // Walking one through every bit of every register, in both timer modes
   task automatic test_bits;
      for (int s = 0; s < 2; s++)
      begin
         wave_split_mode <= s[0];
         for (int r = 0; r < 4; r++)
         begin
            for (int b = 0; b < 8; b++)
            begin
               wr(r, 8'h01 << b);
               rd(r);
               check_pins;
            end
            wr(r, 8'h00);
         end
      end
   endtask : test_bits

   task automatic test_unclaimed;
      set_lanes(1'b0, 1'b1);
      for (int i = 0; i < 4; i++)
         wr(i, 8'hFF);
      check_pins;
      set_lanes(1'b1, 1'b0);
      check_pins;
   endtask : test_unclaimed

   // Read in the data phase of a write to the same word sees the new value
   task automatic test_back_to_back;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= 32'h0000_0004;
      hwrite <= 1'b1;
      hsize <= APRS_HSIZE_WORD;
      htrans <= APRS_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      hwrite <= 1'b0;
      hwdata <= 32'h0000_0004;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      exp_r[1] = 8'h04;
      do @(posedge hclk); while (hready !== 1'b1);
      check("hrdata", 32'h0000_0004, hrdata);
   endtask : test_back_to_back

   // Clock enable low: a write is not taken and the routing holds
   task automatic test_freeze;
      logic [31:0] r;
      clk_en <= 1'b0;
      ahb_xfer(1'b1, 32'h0, APRS_HSIZE_WORD, 32'h0, r);
      clk_en <= 1'b1;
      check_pins;
   endtask : test_freeze

   initial
   begin
      fail_count = 0;
      checked = 0;
      cycles = 0;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = APRS_HSIZE_WORD;
      hwdata = 32'h0;
      wave_split_mode = 1'b0;
      set_lanes(1'b1, 1'b0);
      test_reset;
      test_masks;
      test_reset;
      test_bits;
      test_unclaimed;
      test_back_to_back;
      test_freeze;
      end_of_test;
   end

endmodule : aprs_pin_route_selector_tb
